// [include/abr_pkg.sv]
// package: register map, field layout and timing constants of the converter power control
package abr_pkg;
   // register indexes; the selection register sits at index FFFF_F201
   localparam logic [31:0] IDX_CTRL = 32'hFFFF_F200;
   localparam logic [31:0] IDX_CHTRG = 32'hFFFF_F201;
   localparam logic [31:0] IDX_STATUS = 32'hFFFF_F202;
   localparam logic [31:0] IDX_SETTLE = 32'hFFFF_F203;
   // apb byte address is four times the index; only the low 12 bits are decoded
   localparam logic [11:0] ADDR_CTRL = {IDX_CTRL[9:0], 2'b00};
   localparam logic [11:0] ADDR_CHTRG = {IDX_CHTRG[9:0], 2'b00};
   localparam logic [11:0] ADDR_STATUS = {IDX_STATUS[9:0], 2'b00};
   localparam logic [11:0] ADDR_SETTLE = {IDX_SETTLE[9:0], 2'b00};
   // control register fields
   localparam int CTRL_CONV_BIT = 0;
   localparam int CTRL_BOOST_BIT = 1;
   localparam int CTRL_HS_BIT = 2;
   // channel/trigger register fields
   localparam int CT_EDGE_HI = 7;
   localparam int CT_EDGE_LO = 6;
   localparam int CT_TRGMODE = 5;
   localparam int CT_HWSRC = 4;
   localparam int CT_FIXED0 = 3;
   localparam int CT_CH_HI = 2;
   localparam logic [7:0] CHTRG_RESET = 8'h00;
   localparam logic [7:0] CHTRG_WMASK = 8'hF7;
   // boost reference settle times
   localparam int CLK_MHZ = 200;
   localparam int SETTLE_HS_US = 1;
   localparam int SETTLE_NORM_US = 14;
   localparam logic [11:0] SETTLE_HS_CYC = 12'(SETTLE_HS_US * CLK_MHZ);
   localparam logic [11:0] SETTLE_NORM_CYC = 12'(SETTLE_NORM_US * CLK_MHZ);
   // operating modes
   typedef enum logic [1:0] {ABR_STOPPED, ABR_STANDBY, ABR_CONVERTING} abr_mode_t;
   // edge selection encodings
   typedef enum logic [1:0] {EDGE_NONE, EDGE_FALL, EDGE_RISE, EDGE_BOTH} abr_edge_t;
   // apb request carrier
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } abr_apb_req_t;
   // analog-side controls
   typedef struct packed {
      logic boostOn;
      logic convRun;
      logic [2:0] channel;
   } abr_analog_t;
endpackage

// [design/abr_edge_detect.sv]
// edge detector for the external conversion trigger pin
`timescale 1ns/100ps
`default_nettype none
module abr_edge_detect (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // trigger pin and selection
   input wire logic extTrigPin,
   input wire logic [1:0] edgeSel,
   // detected event
   output logic trigPulse
);
   import abr_pkg::*;
   logic pinDly_reg;
   logic rise;
   logic fall;

   // pin taken as synchronous; one stage of history
   always_ff @(posedge clock) begin
      if (reset) begin
         pinDly_reg <= 1'b0;
      end else begin
         pinDly_reg <= extTrigPin;
      end
   end

   assign rise = extTrigPin & ~pinDly_reg;
   assign fall = ~extTrigPin & pinDly_reg;

   always_comb begin
      unique case (abr_edge_t'(edgeSel))
         EDGE_NONE: trigPulse = 1'b0;
         EDGE_FALL: trigPulse = fall;
         EDGE_RISE: trigPulse = rise;
         EDGE_BOTH: trigPulse = rise | fall;
      endcase
   end

   property p_no_edge_quiet;
      @(posedge clock) disable iff (reset) (edgeSel == 2'h0) |-> !trigPulse;
   endproperty
   a_no_edge_quiet: assert property (p_no_edge_quiet) else $error("trigger with no edge sel");
endmodule
`default_nettype wire

// [design/abr_power_ctrl.sv]
// converter power-state control with channel and trigger selection over apb
//
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - boost enable low powers boost generator down unless conversion enables it.
// - both enables low means fully stopped, no static current.
// - conversion low, boost high means standby, only boost generator powered.
// - 00 to 10 enters conversion and turns boost generator on.
// - clearing conversion with boost low turns boost generator off.
// - 00 to 11 enters conversion with boost generator on.
// - clearing conversion with boost high keeps boost generator running.
// - channel/trigger register byte or bit accessible, resets to zero.
// - bits 7:6 edge, 5 mode, 4 source, 3 zero, 2:0 channel.
module abr_power_ctrl (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // apb slave
   input wire abr_pkg::abr_apb_req_t apbReq,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,
   // external trigger
   input wire logic extConversionTriggerPin,
   // analog controls and triggers
   output var abr_pkg::abr_analog_t analogCtl,
   output logic convStart,
   output logic boostSettled
);
   import abr_pkg::*;

   // ==========================================================
   // bus decode
   // ==========================================================
   logic access;
   logic wrEn;
   logic hitCtrl;
   logic hitChtrg;
   logic hitStatus;
   logic hitSettle;
   logic mapped;

   // one compare per register; shared so every decode sees the same window width
   function automatic logic isAddr(input logic [11:0] addr, input logic [11:0] regAddr);
      return addr == regAddr;
   endfunction

   assign access = apbReq.psel & apbReq.penable;
   assign hitCtrl = isAddr(apbReq.paddr, ADDR_CTRL);
   assign hitChtrg = isAddr(apbReq.paddr, ADDR_CHTRG);
   assign hitStatus = isAddr(apbReq.paddr, ADDR_STATUS);
   assign hitSettle = isAddr(apbReq.paddr, ADDR_SETTLE);
   assign mapped = hitCtrl | hitChtrg | hitStatus | hitSettle;
   assign wrEn = access & apbReq.pwrite & mapped;
   // zero-wait slave; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = access & ~mapped;

   // ==========================================================
   // registers
   // ==========================================================
   logic [2:0] ctrl_reg;
   logic [7:0] chtrg_reg;
   logic [7:0] chtrgWr;
   logic [2:0] ctrlWr;

   // only the three control bits are kept; upper write data is ignored
   assign ctrlWr = apbReq.pwdata[2:0];

   // control: conversion enable, boost enable, high-speed select
   always_ff @(posedge clock) begin
      if (reset) begin
         ctrl_reg <= 3'h0;
      end else if (wrEn && hitCtrl && pstrb[0]) begin
         ctrl_reg <= ctrlWr;
      end
   end

   assign chtrgWr = apbReq.pwdata[7:0] & CHTRG_WMASK;

   // byte lane write, reset to zero
   always_ff @(posedge clock) begin
      if (reset) begin
         chtrg_reg <= CHTRG_RESET;
      end else if (wrEn && hitChtrg && pstrb[0]) begin
         chtrg_reg <= chtrgWr;
      end
   end

   logic convEn;
   logic boostEn;
   logic highSpeed;
   assign convEn = ctrl_reg[CTRL_CONV_BIT];
   assign boostEn = ctrl_reg[CTRL_BOOST_BIT];
   assign highSpeed = ctrl_reg[CTRL_HS_BIT];

   // ==========================================================
   // power state
   // ==========================================================
   abr_mode_t mode;

   always_comb begin
      unique case ({convEn, boostEn})
         2'b00: mode = ABR_STOPPED;
         2'b01: mode = ABR_STANDBY;
         2'b10: mode = ABR_CONVERTING;
         2'b11: mode = ABR_CONVERTING;
      endcase
   end

   logic boostOn_reg;
   logic convRun_reg;
   always_ff @(posedge clock) begin
      if (reset) begin
         boostOn_reg <= 1'b0;
         convRun_reg <= 1'b0;
      end else begin
         boostOn_reg <= (mode != ABR_STOPPED);
         convRun_reg <= (mode == ABR_CONVERTING);
      end
   end

   // ==========================================================
   // settle timer: status aid for software wait
   // ==========================================================
   logic [11:0] settleCnt_reg;
   logic [11:0] settleLimit;
   logic settled_reg;
   assign settleLimit = highSpeed ? SETTLE_HS_CYC : SETTLE_NORM_CYC;

   // a speed change mid-count keeps the count; the new limit applies at once
   // count from boost turn-on
   always_ff @(posedge clock) begin
      if (reset || !boostOn_reg) begin
         settleCnt_reg <= 12'h000;
         settled_reg <= 1'b0;
      end else if (!settled_reg) begin
         settleCnt_reg <= settleCnt_reg + 12'h001;
         settled_reg <= (settleCnt_reg + 12'h001) >= settleLimit;
      end
   end
   assign boostSettled = settled_reg;

   // ==========================================================
   // trigger path
   // ==========================================================
   // the pin is taken as synchronous; a free-running source needs a synchroniser first
   logic edgeHit;
   abr_edge_detect uEdge (
      .clock(clock),
      .reset(reset),
      .extTrigPin(extConversionTriggerPin),
      .edgeSel(chtrg_reg[CT_EDGE_HI:CT_EDGE_LO]),
      .trigPulse(edgeHit)
   );

   logic convStart_reg;
   // registered so the start strobe cannot glitch; it costs one cycle of latency
   // hardware mode, external source (source bit 0) starts conversions
   always_ff @(posedge clock) begin
      if (reset) begin
         convStart_reg <= 1'b0;
      end else begin
         convStart_reg <= convRun_reg & chtrg_reg[CT_TRGMODE] & ~chtrg_reg[CT_HWSRC] & edgeHit;
      end
   end
   assign convStart = convStart_reg;

   // one driver for the whole carrier, every field from a flop
   assign analogCtl = '{boostOn: boostOn_reg, convRun: convRun_reg,
      channel: chtrg_reg[CT_CH_HI:0]};

   // ==========================================================
   // read data
   // ==========================================================
   logic [31:0] rdNext;
   logic [31:0] prdata_reg;
   always_comb begin
      rdNext = 32'h0000_0000;
      if (hitCtrl) rdNext = {29'h0, ctrl_reg};
      if (hitChtrg) rdNext = {24'h0, chtrg_reg};
      if (hitStatus) rdNext = {28'h0, settled_reg, convRun_reg, boostOn_reg, 1'b0} | {30'h0, mode};
      if (hitSettle) rdNext = {20'h0, settleCnt_reg};
   end
   // registered read data, captured in the setup cycle
   always_ff @(posedge clock) begin
      if (reset) begin
         prdata_reg <= 32'h0000_0000;
      end else if (apbReq.psel && !apbReq.penable && !apbReq.pwrite) begin
         prdata_reg <= rdNext;
      end
   end
   assign prdata = prdata_reg;

   // ==========================================================
   // assertions
   // ==========================================================
   property p_stopped;
      @(posedge clock) disable iff (reset) (!convEn && !boostEn) |=> !boostOn_reg && !convRun_reg;
   endproperty
   a_stopped: assert property (p_stopped) else $error("not stopped with enables low");

   property p_standby;
      @(posedge clock) disable iff (reset) (!convEn && boostEn) |=> boostOn_reg && !convRun_reg;
   endproperty
   a_standby: assert property (p_standby) else $error("standby wrong");

   property p_conv10;
      @(posedge clock) disable iff (reset) (convEn && !boostEn) |=> boostOn_reg && convRun_reg;
   endproperty
   a_conv10: assert property (p_conv10) else $error("10 boost not on");

   property p_conv11;
      @(posedge clock) disable iff (reset) (convEn && boostEn) |=> boostOn_reg && convRun_reg;
   endproperty
   a_conv11: assert property (p_conv11) else $error("11 boost not on");

   property p_off_clear;
      @(posedge clock) disable iff (reset) $fell(convEn) && !boostEn |=> !boostOn_reg;
   endproperty
   a_off_clear: assert property (p_off_clear) else $error("boost stayed on");

   property p_keep;
      @(posedge clock) disable iff (reset) $fell(convEn) && boostEn |=> boostOn_reg;
   endproperty
   a_keep: assert property (p_keep) else $error("boost dropped");

   property p_boost_off;
      @(posedge clock) disable iff (reset) boostOn_reg |-> $past(convEn) || $past(boostEn);
   endproperty
   a_boost_off: assert property (p_boost_off) else $error("boost on without enable");

   property p_bit3;
      @(posedge clock) disable iff (reset) chtrg_reg[CT_FIXED0] == 1'b0;
   endproperty
   a_bit3: assert property (p_bit3) else $error("fixed bit set");

   property p_write;
      @(posedge clock) disable iff (reset) wrEn && hitChtrg && pstrb[0] |=> chtrg_reg == $past(chtrgWr);
   endproperty
   a_write: assert property (p_write) else $error("register not written");

   property p_settle_hs;
      @(posedge clock) disable iff (reset) $rose(boostOn_reg) && highSpeed ##1 highSpeed [*8] |-> !settled_reg;
   endproperty
   a_settle_hs: assert property (p_settle_hs) else $error("settled too soon");

   property p_read_chtrg;
      @(posedge clock) disable iff (reset)
         access && !apbReq.pwrite && hitChtrg |-> prdata == {24'h0, chtrg_reg};
   endproperty
   a_read_chtrg: assert property (p_read_chtrg) else $error("bad read back");

   property p_write_refused;
      @(posedge clock) disable iff (reset)
         access && apbReq.pwrite && !(mapped && pstrb[0])
         |=> $stable(chtrg_reg) && $stable(ctrl_reg);
   endproperty
   a_write_refused: assert property (p_write_refused) else $error("refused write");

   property p_ctrl_write;
      @(posedge clock) disable iff (reset)
         wrEn && hitCtrl && pstrb[0] |=> ctrl_reg == $past(ctrlWr);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("enables not written");

   property p_sw_quiet;
      @(posedge clock) disable iff (reset)
         !chtrg_reg[CT_TRGMODE] |=> !convStart;
   endproperty
   a_sw_quiet: assert property (p_sw_quiet) else $error("start in software mode");

   property p_idle_quiet;
      @(posedge clock) disable iff (reset)
         !convRun_reg |=> !convStart;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("start while idle");

   property p_start_edge;
      @(posedge clock) disable iff (reset)
         convStart |-> $past(edgeHit);
   endproperty
   a_start_edge: assert property (p_start_edge) else $error("start without edge");

   property p_settle_drop;
      @(posedge clock) disable iff (reset)
         !boostOn_reg |=> !settled_reg && settleCnt_reg == 12'h000;
   endproperty
   a_settle_drop: assert property (p_settle_drop) else $error("settle kept");

   property p_settle_count;
      @(posedge clock) disable iff (reset)
         $rose(settled_reg) |-> settleCnt_reg >= $past(settleLimit);
   endproperty
   a_settle_count: assert property (p_settle_count) else $error("settled early");

   c_standby: cover property (@(posedge clock) disable iff (reset) mode == ABR_STANDBY);
   c_settled: cover property (@(posedge clock) disable iff (reset) $rose(settled_reg));
   c_keep: cover property (@(posedge clock) disable iff (reset) $fell(convRun_reg) && boostOn_reg);
   c_conv: cover property (@(posedge clock) disable iff (reset) $rose(convRun_reg));
   c_start: cover property (@(posedge clock) disable iff (reset) convStart);
endmodule
`default_nettype wire

// [dv/abr_trig_source.sv]
// model of the external trigger source that drives the conversion trigger pin
`timescale 1ns/100ps
`default_nettype none
module abr_trig_source (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // requested level, settle status and pin
   input wire logic want,
   input wire logic settled,
   output logic pin
);
   // =====================================
   // pin drive
   // edges only after settle
   // the pin holds its level until the boost reference has settled,
   // so no conversion is ever started on an unsettled reference
   always_ff @(posedge clock) begin
      if (reset) begin
         pin <= 1'b0;
      end else if (settled) begin
         pin <= want;
      end
   end
endmodule
`default_nettype wire

// [dv/abr_power_ctrl_bench.sv]
// self-checking bench for the converter power control block
`timescale 1ns/100ps
`default_nettype none
module abr_power_ctrl_bench;
   import abr_pkg::*;
   // =====================================
   // signals
   logic clock, reset, pready, pslverr, convStart, boostSettled, trigWant, trigPin, err;
   logic [3:0] pstrb;
   logic [31:0] prdata, rd;
   abr_apb_req_t req;
   abr_analog_t ana;
   int nMismatch, totalChecks, cycles, pulses;
   // written value beside the value read back
   logic [7:0] rows [4][2] = '{'{8'hFF, 8'hF7}, '{8'h08, 8'h00}, '{8'h5A, 8'h52}, '{8'hA5, 8'hA5}};

   abr_power_ctrl u_dut (.clock(clock), .reset(reset), .apbReq(req), .pstrb(pstrb),
      .pready(pready), .pslverr(pslverr), .prdata(prdata), .extConversionTriggerPin(trigPin),
      .analogCtl(ana), .convStart(convStart), .boostSettled(boostSettled));
   abr_trig_source u_src (.clock(clock), .reset(reset), .want(trigWant),
      .settled(boostSettled), .pin(trigPin));

   // =====================================
   // clock
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // pulse counter and hang guard; the run needs about 3300 cycles
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (convStart === 1'b1) begin
         pulses <= pulses + 1;
      end
      if (cycles == 8000) begin
         nMismatch = nMismatch + 1;
         close_out();
      end
   end

   // =====================================
   // tasks
   task close_out;
      if (nMismatch == 0 && totalChecks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      totalChecks = totalChecks + 1;
      if (got !== exp) begin
         nMismatch = nMismatch + 1;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one apb transfer; data and error taken at the edge where pready is seen
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge clock);
      req.penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask

   // write the enables and look at the analog controls a cycle later
   task setctl(input logic [2:0] v, input logic eb, input logic ec);
      apb(1'b1, ADDR_CTRL, {29'h0, v});
      @(posedge clock);
      #1;
      chk({30'h0, ana.boostOn, ana.convRun}, {30'h0, eb, ec});
   endtask

   // move the trigger pin and count start pulses that follow
   task trig(input logic lvl, input int exp);
      int p0;
      p0 = pulses;
      @(posedge clock);
      trigWant <= lvl;
      repeat (8) @(posedge clock);
      #1;
      chk(32'(pulses - p0), 32'(exp));
   endtask

   // =====================================
   // main sequence
   initial begin
      reset = 1'b1;
      req = '0;
      pstrb = 4'hF;
      trigWant = 1'b0;
      repeat (20) @(posedge clock);
      reset <= 1'b0;
      apb(1'b0, ADDR_CHTRG, 32'h0);
      chk(rd, 32'h0);
      chk({27'h0, ana}, 32'h0);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, ADDR_CHTRG, {24'h0, rows[i][0]});
         apb(1'b0, ADDR_CHTRG, 32'h0);
         chk(rd, {24'h0, rows[i][1]});
         chk({29'h0, ana.channel}, {29'h0, rows[i][0][2:0]});
      end
      // lane 0 strobe low leaves the register alone
      pstrb <= 4'hE;
      apb(1'b1, ADDR_CHTRG, 32'h11);
      pstrb <= 4'hF;
      apb(1'b0, ADDR_CHTRG, 32'h0);
      chk(rd, 32'hA5);
      apb(1'b0, 12'h2F0, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      // power state walk
      setctl(3'b001, 1'b1, 1'b1);
      setctl(3'b000, 1'b0, 1'b0);
      setctl(3'b010, 1'b1, 1'b0);
      setctl(3'b000, 1'b0, 1'b0);
      setctl(3'b011, 1'b1, 1'b1);
      setctl(3'b010, 1'b1, 1'b0);
      setctl(3'b000, 1'b0, 1'b0);
      // wait the high-speed settle time before conversion
      setctl(3'b110, 1'b1, 1'b0);
      repeat (int'(SETTLE_HS_CYC) - 20) @(posedge clock);
      chk({31'h0, boostSettled}, 32'h0);
      repeat (40) @(posedge clock);
      chk({31'h0, boostSettled}, 32'h1);
      setctl(3'b111, 1'b1, 1'b1);
      // every edge selection in hardware mode with the pin as source
      for (int e = 0; e < 4; e++) begin
         apb(1'b1, ADDR_CHTRG, {24'h0, 2'(e), 6'h20});
         trig(1'b1, e / 2);
         trig(1'b0, e % 2);
      end
      // hardware mode with the internal source, and software mode with the pin as source, ignore the pin
      apb(1'b1, ADDR_CHTRG, 32'hF0);
      trig(1'b1, 0);
      trig(1'b0, 0);
      apb(1'b1, ADDR_CHTRG, 32'hC0);
      trig(1'b1, 0);
      trig(1'b0, 0);
      // normal-speed settle time from a fresh boost turn-on
      setctl(3'b000, 1'b0, 1'b0);
      setctl(3'b010, 1'b1, 1'b0);
      repeat (int'(SETTLE_NORM_CYC) - 20) @(posedge clock);
      chk({31'h0, boostSettled}, 32'h0);
      repeat (40) @(posedge clock);
      chk({31'h0, boostSettled}, 32'h1);
      // status: settled, boost on, standby
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd, 32'hB);
      // a reset in mid-run clears the selection register and the enables
      @(posedge clock);
      reset <= 1'b1;
      repeat (3) @(posedge clock);
      reset <= 1'b0;
      apb(1'b0, ADDR_CHTRG, 32'h0);
      chk(rd, 32'h0);
      chk({27'h0, ana}, 32'h0);
      close_out();
   end
endmodule
`default_nettype wire
